// [boot_sel_pkg.sv]
`default_nettype none
package boot_sel_pkg;

  // option field and address widths
  localparam int ADDR_W = 32;
  localparam int FIELD_W = 25;
  localparam int FIELD_LSB = 7;
  localparam int SVC_CMD_W = 8;

  // factory default option fields (address bits [31:7])
  localparam logic [FIELD_W-1:0] NS_ADDR0_DEFAULT = 25'h0100000;
  localparam logic [FIELD_W-1:0] NS_ADDR1_DEFAULT = 25'h017f200;
  localparam logic [FIELD_W-1:0] SEC_ADDR_DEFAULT = 25'h0180000;

  // fixed entry point of the root security service
  localparam logic [ADDR_W-1:0] SERVICE_BOOT_ADDR = 32'h0ff80000;

  // reset value of the boot address output
  localparam logic [ADDR_W-1:0] BOOT_ADDR_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    TGT_NS_FIELD0 = 2'b00,
    TGT_NS_FIELD1 = 2'b01,
    TGT_SECURE = 2'b10,
    TGT_SERVICE = 2'b11
  } boot_target_t;

  typedef enum logic [1:0] {
    SEL_HOLD = 2'b00,
    SEL_CAPTURE = 2'b01,
    SEL_DECODE = 2'b10,
    SEL_READY = 2'b11
  } sel_state_t;

  // option and pin snapshot taken at reset release
  typedef struct packed {
    logic boot_strap_pin;
    logic option_boot_select_bit;
    logic boot_source_select_bit;
    logic security_extension_enable;
    logic boot_lock_bit;
    logic [SVC_CMD_W-1:0] service_command;
    logic [FIELD_W-1:0] nonsecure_boot_addr_0;
    logic [FIELD_W-1:0] nonsecure_boot_addr_1;
    logic [FIELD_W-1:0] secure_boot_addr;
  } boot_inputs_t;

endpackage : boot_sel_pkg
`default_nettype wire

// [boot_sel_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface boot_sel_if;
  import boot_sel_pkg::*;

  boot_inputs_t snap;
  boot_target_t target;
  logic [ADDR_W-1:0] addr;

  modport decoder (input snap, output target, output addr);
  modport requester (output snap, input target, input addr);

endinterface : boot_sel_if
`default_nettype wire

// [boot_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module boot_decode
  import boot_sel_pkg::*;
(
  boot_sel_if.decoder sel
);

  always_comb begin
    boot_target_t tgt;
    tgt = TGT_NS_FIELD0;
    if (sel.snap.security_extension_enable) begin
      if (sel.snap.boot_lock_bit) begin
        // lock forces the single secure entry
        tgt = TGT_SECURE;
      end else if (sel.snap.service_command != '0) begin
        tgt = TGT_SERVICE;
      end else if (!sel.snap.boot_strap_pin && sel.snap.boot_source_select_bit) begin
        tgt = TGT_SECURE;
      end else begin
        tgt = TGT_SERVICE;
      end
    end else if (sel.snap.boot_source_select_bit) begin
      // pin chooses the field
      tgt = sel.snap.boot_strap_pin ? TGT_NS_FIELD1 : TGT_NS_FIELD0;
    end else begin
      // pin ignored, option bit chooses
      tgt = sel.snap.option_boot_select_bit ? TGT_NS_FIELD0 : TGT_NS_FIELD1;
    end
    sel.target = tgt;
    case (tgt)
      TGT_NS_FIELD0: begin
        sel.addr = {sel.snap.nonsecure_boot_addr_0, {FIELD_LSB{1'b0}}};
      end
      TGT_NS_FIELD1: begin
        sel.addr = {sel.snap.nonsecure_boot_addr_1, {FIELD_LSB{1'b0}}};
      end
      TGT_SECURE: begin
        sel.addr = {sel.snap.secure_boot_addr, {FIELD_LSB{1'b0}}};
      end
      TGT_SERVICE: begin
        sel.addr = SERVICE_BOOT_ADDR;
      end
      default: begin
        sel.addr = BOOT_ADDR_RESET;
      end
    endcase
  end

endmodule // boot_decode
`default_nettype wire

// [boot_address_selector.sv]
// What this block does
// - boot address comes from strap pin, option select bit and 25-bit option fields
// - targets: user flash, system bootloader, embedded SRAM, root security service
// - security off, source select 1: pin low gives field 0, high gives field 1
// - security off, source select 0: pin ignored; option bit 1 field 0, 0 field 1
// - factory defaults: field 0 user flash, field 1 system bootloader
// - security on: boot from the secure 25-bit address field or the root security service
// - security on, lock set: always secure field, ignore pin, select bits and service command
// - security on, unlocked, no command, pin low, source select 1: secure field
// - security on, unlocked: nonzero command or other combinations boot the service
// - root security service is a target only with security enabled
// - strap pin sampled again on wake from deepest standby
`timescale 1ns/1ps
`default_nettype none
module boot_address_selector
  import boot_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic boot_strap_pin,
  input wire logic option_boot_select_bit,
  input wire logic boot_source_select_bit,
  input wire logic security_extension_enable,
  input wire logic boot_lock_bit,
  input wire logic [SVC_CMD_W-1:0] service_command,
  input wire logic option_bytes_programmed,
  input wire logic [FIELD_W-1:0] nonsecure_boot_addr_0,
  input wire logic [FIELD_W-1:0] nonsecure_boot_addr_1,
  input wire logic [FIELD_W-1:0] secure_boot_addr,
  input wire logic standby_wake,
  input wire logic boot_fetch_req,
  output logic boot_fetch_ack,
  output logic boot_valid,
  output logic [ADDR_W-1:0] boot_addr,
  output logic [1:0] boot_target,
  output logic boot_secure
);

  typedef struct packed {
    sel_state_t state;
    boot_inputs_t snap;
    logic [ADDR_W-1:0] addr;
    boot_target_t target;
    logic valid;
    logic secure;
  } sel_regs_t;

  sel_regs_t sel_r;
  sel_regs_t sel_nxt;

  boot_sel_if sel ();

  boot_decode u_decode (
    .sel(sel.decoder)
  );

  assign sel.snap = sel_r.snap;

  // live inputs, factory defaults when options are blank
  boot_inputs_t live;

  always_comb begin
    live.boot_strap_pin = boot_strap_pin;
    live.option_boot_select_bit = option_boot_select_bit;
    live.boot_source_select_bit = boot_source_select_bit;
    live.security_extension_enable = security_extension_enable;
    live.boot_lock_bit = boot_lock_bit;
    live.service_command = service_command;
    if (option_bytes_programmed) begin
      live.nonsecure_boot_addr_0 = nonsecure_boot_addr_0;
      live.nonsecure_boot_addr_1 = nonsecure_boot_addr_1;
      live.secure_boot_addr = secure_boot_addr;
    end else begin
      live.nonsecure_boot_addr_0 = NS_ADDR0_DEFAULT;
      live.nonsecure_boot_addr_1 = NS_ADDR1_DEFAULT;
      live.secure_boot_addr = SEC_ADDR_DEFAULT;
    end
  end

  always_comb begin
    sel_nxt = sel_r;
    case (sel_r.state)
      SEL_HOLD: begin
        // first edge after reset release
        sel_nxt.valid = 1'b0;
        sel_nxt.state = SEL_CAPTURE;
      end
      SEL_CAPTURE: begin
        sel_nxt.snap = live;
        sel_nxt.valid = 1'b0;
        sel_nxt.state = SEL_DECODE;
      end
      SEL_DECODE: begin
        sel_nxt.addr = sel.addr;
        sel_nxt.target = sel.target;
        sel_nxt.secure = sel_r.snap.security_extension_enable;
        sel_nxt.valid = 1'b1;
        sel_nxt.state = SEL_READY;
      end
      SEL_READY: begin
        // held until reset or standby wake
        if (standby_wake) begin
          sel_nxt.valid = 1'b0;
          sel_nxt.state = SEL_CAPTURE;
        end
      end
      default: begin
        sel_nxt.state = SEL_HOLD;
        sel_nxt.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_r <= '{state: SEL_HOLD, snap: '0, addr: BOOT_ADDR_RESET, target: TGT_NS_FIELD0,
                 valid: 1'b0, secure: 1'b0};
    end else begin
      sel_r <= sel_nxt;
    end
  end

  assign boot_valid = sel_r.valid;
  assign boot_addr = sel_r.addr;
  assign boot_target = sel_r.target;
  assign boot_secure = sel_r.secure;
  assign boot_fetch_ack = boot_fetch_req & sel_r.valid;

endmodule // boot_address_selector
`default_nettype wire

// [boot_sel_props.sv]
`timescale 1ns/1ps
`default_nettype none
module boot_sel_props
  import boot_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic standby_wake,
  input wire logic boot_fetch_req,
  input wire logic boot_fetch_ack,
  input wire logic boot_valid,
  input wire logic [ADDR_W-1:0] boot_addr,
  input wire logic [1:0] boot_target,
  input wire logic boot_secure
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_valid: assert property (boot_fetch_ack == (boot_fetch_req && boot_valid)) else $error("bad ack");
  chk_sec_target: assert property (boot_valid && boot_secure |-> boot_target[1]) else $error("bad sec");
  chk_ns_target: assert property (boot_valid && !boot_secure |-> !boot_target[1]) else $error("bad ns");
  chk_service_addr: assert property (boot_valid && boot_target == 2'h3 |-> boot_addr == SERVICE_BOOT_ADDR)
    else $error("bad service address");
  chk_field_addr: assert property (boot_valid && boot_target != 2'h3 |-> boot_addr[6:0] == 7'h00)
    else $error("bad field");
  chk_hold_addr: assert property (boot_valid && !standby_wake |=> boot_valid && $stable(boot_addr))
    else $error("not held");
  chk_wake_redo: assert property (boot_valid && standby_wake |=> !boot_valid ##[1:3] boot_valid)
    else $error("bad wake");
  chk_rst_load: assert property ($fell(rst) |-> !boot_valid ##[2:3] boot_valid) else $error("bad load");
  cover property (boot_fetch_ack);
  cover property (boot_valid && boot_target == 2'h3);
  cover property (boot_valid && standby_wake);
endmodule // boot_sel_props
bind boot_address_selector boot_sel_props props_u (.clk(clk), .rst(rst), .standby_wake(standby_wake),
  .boot_fetch_req(boot_fetch_req), .boot_fetch_ack(boot_fetch_ack), .boot_valid(boot_valid),
  .boot_addr(boot_addr), .boot_target(boot_target), .boot_secure(boot_secure));
`default_nettype wire

// [boot_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module boot_core_model
  import boot_sel_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  output logic boot_fetch_req,
  input wire logic boot_fetch_ack,
  input wire logic [ADDR_W-1:0] boot_addr,
  output logic [ADDR_W-1:0] fetched_addr,
  output logic got
);
  // request held until ack seen at a rising edge
  initial begin
    boot_fetch_req = 1'b0;
    got = 1'b0;
    fetched_addr = '0;
    forever begin
      @(posedge clk);
      if (go) begin
        boot_fetch_req <= 1'b1;
        got <= 1'b0;
      end else if (boot_fetch_req && boot_fetch_ack) begin
        boot_fetch_req <= 1'b0;
        got <= 1'b1;
        fetched_addr <= boot_addr;
      end
    end
  end
endmodule // boot_core_model
`default_nettype wire

// [test_boot_address_selector.sv]
`timescale 1ns/1ps
`default_nettype none
module test_boot_address_selector;
  import boot_sel_pkg::*;
  logic clk, rst, go, got, pin, opt, src, sec, lock, prog, wake, req, ack, valid, bsec;
  logic [SVC_CMD_W-1:0] cmd;
  logic [FIELD_W-1:0] n0 = 25'h0012345, n1 = 25'h0054321, sa = 25'h0177777;
  logic [ADDR_W-1:0] addr, fetched;
  logic [1:0] tgt;
  int err_total = 0, check_count = 0;
  boot_address_selector dut_u (.clk(clk), .rst(rst), .boot_strap_pin(pin), .option_boot_select_bit(opt),
    .boot_source_select_bit(src), .security_extension_enable(sec), .boot_lock_bit(lock), .service_command(cmd),
    .option_bytes_programmed(prog), .nonsecure_boot_addr_0(n0), .nonsecure_boot_addr_1(n1),
    .secure_boot_addr(sa), .standby_wake(wake), .boot_fetch_req(req), .boot_fetch_ack(ack),
    .boot_valid(valid), .boot_addr(addr), .boot_target(tgt), .boot_secure(bsec));
  boot_core_model core_u (.clk(clk), .go(go), .boot_fetch_req(req), .boot_fetch_ack(ack),
    .boot_addr(addr), .fetched_addr(fetched), .got(got));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic results();
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fetch(input logic [1:0] et, input logic [ADDR_W-1:0] ea);
    int i;
    go = 1;
    @(negedge clk);
    go = 0;
    for (i = 0; i < 20 && got !== 1'b1; i++) @(negedge clk);
    check_count++;
    if (!(got === 1'b1 && tgt === et && fetched === ea)) begin
      err_total++;
      $display("MISMATCH %0t boot %h target %0d", $time, fetched, tgt);
      if (got !== 1'b1) results();
    end
    check_count++;
    if (!(valid === 1'b1 && bsec === sec)) begin
      err_total++;
      $display("MISMATCH %0t valid %b secure %b", $time, valid, bsec);
    end
  endtask
  task automatic boot(input logic [5:0] c, input logic [7:0] k, input logic [1:0] et, input logic [31:0] ea);
    {sec, lock, src, opt, pin, prog} = c;
    cmd = k;
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    fetch(et, ea);
  endtask
  task automatic t_nonsec();
    boot(6'h09, 8'h00, TGT_NS_FIELD0, {n0, 7'h00});
    boot(6'h0b, 8'h00, TGT_NS_FIELD1, {n1, 7'h00});
    boot(6'h07, 8'h00, TGT_NS_FIELD0, {n0, 7'h00});
    boot(6'h01, 8'h00, TGT_NS_FIELD1, {n1, 7'h00});
    boot(6'h0b, 8'hff, TGT_NS_FIELD1, {n1, 7'h00});
  endtask
  task automatic t_secure();
    boot(6'h29, 8'h00, TGT_SECURE, {sa, 7'h00});
    boot(6'h2b, 8'h00, TGT_SERVICE, SERVICE_BOOT_ADDR);
    boot(6'h27, 8'h00, TGT_SERVICE, SERVICE_BOOT_ADDR);
    boot(6'h29, 8'h5a, TGT_SERVICE, SERVICE_BOOT_ADDR);
    boot(6'h37, 8'hff, TGT_SECURE, {sa, 7'h00});
  endtask
  task automatic t_defaults();
    boot(6'h08, 8'h00, TGT_NS_FIELD0, 32'h08000000);
    boot(6'h0a, 8'h00, TGT_NS_FIELD1, 32'h0bf90000);
    boot(6'h28, 8'h00, TGT_SECURE, 32'h0c000000);
  endtask
  task automatic t_wake();
    boot(6'h09, 8'h00, TGT_NS_FIELD0, {n0, 7'h00});
    pin = 1;
    repeat (4) @(negedge clk);
    fetch(TGT_NS_FIELD0, {n0, 7'h00});
    wake = 1;
    @(negedge clk);
    wake = 0;
    fetch(TGT_NS_FIELD1, {n1, 7'h00});
  endtask
  initial begin
    {rst, go, wake, pin, opt, src, sec, lock, prog} = 9'h101;
    cmd = 8'h00;
    t_nonsec();
    t_secure();
    t_defaults();
    t_wake();
    results();
  end
endmodule // test_boot_address_selector
`default_nettype wire
